// ==== core/clock_gen_defines.vh ====
// Register offsets, field positions, reset values and timing counts for the clock generator controls.
// Assumes inclusion by bare name from the core files.
`ifndef CLOCK_GEN_DEFINES_VH
`define CLOCK_GEN_DEFINES_VH
`define CTRL_ONE_OFFSET 12'h000
`define CTRL_TWO_OFFSET 12'h004
`define STATUS_OFFSET 12'h008
`define CTRL_ONE_RESET 8'h04
`define CTRL_TWO_RESET 8'h40
`define SRC_SEL_HI 7
`define SRC_SEL_LO 6
`define REF_DIV_HI 5
`define REF_DIV_LO 3
`define INT_REF_CHOOSE_BIT 2
`define INT_REF_OE_BIT 1
`define INT_REF_STOP_BIT 0
`define BUS_DIV_HI 7
`define BUS_DIV_LO 6
`define RANGE_BIT 5
`define HIGH_GAIN_BIT 4
`define LOW_POWER_BIT 3
`define EXT_SRC_BIT 2
`define EXT_REF_OE_BIT 1
`define EXT_REF_STOP_BIT 0
`define SRC_LOOP 2'h0
`define SRC_INTERNAL 2'h1
`define SRC_EXTERNAL 2'h2
`define SRC_RESERVED 2'h3
`define SYNC_STAGES 2
`define LOCK_WAIT_CYCLES 64
`endif

// ==== core/pow2_divider.v ====
// Divide-by-two-to-the-power enable divider.
// Assumes en_in is a one-cycle enable of the source rate.
`timescale 1ns/1ps
module pow2_divider #(
    parameter SEL_W = 3,
    parameter CNT_W = 7
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Source enable and power selection
    input wire en_in,
    input wire [SEL_W-1:0] power_sel,
    // Divided enable
    output wire en_out
);
    reg [CNT_W-1:0] count_q;
    wire [CNT_W-1:0] mask = ~({CNT_W{1'b1}} << power_sel);
    // Terminal count under the mask; code 0 passes every enable
    assign en_out = en_in && ((count_q & mask) == mask);
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= {CNT_W{1'b0}};
        end else if (en_in) begin
            count_q <= count_q + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
endmodule // pow2_divider

// ==== core/level_sync.v ====
// Two-stage level synchroniser, used to delay status until the crossing settles.
// Assumes d_in is a level.
`timescale 1ns/1ps
module level_sync #(
    parameter W = 2
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Level in and settled level out
    input wire [W-1:0] d_in,
    output reg [W-1:0] q_out
);
    reg [W-1:0] meta_q;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= {W{1'b0}};
            q_out <= {W{1'b0}};
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end
endmodule // level_sync

// ==== core/clock_generator_control_regs.v ====
// Clock generator control registers with AXI4-Lite slave, source routing and stop gating.
// Assumes one clock; reference and loop clocks arrive as enable pulses on clk_sys.
// Functional notes
// - Source field 00 loop, 01 internal, 10 external reference for system clock.
// - Source code 11 behaves as loop output.
// - Reference divider divides by two to the code, reset divide-by-one.
// - Reference select bit one picks internal, zero external loop reference.
// - Internal reference output enable gates the internal clock output.
// - Internal stop bit keeps internal reference in stop if enabled or internal mode.
// - Bus divider divides system clock by 1, 2, 4, 8; reset divide-by-two.
// - Range bit selects high or low external frequency range.
// - High gain bit selects high gain versus low power oscillator.
// - Low power bit disables loop in bypassed modes.
// - External source bit requests crystal oscillator or external clock.
// - External reference output enable gates the external clock output.
// - External stop bit keeps external reference in stop if enabled or external mode.
// - Mode status follows source select only after synchronisation.
// - Changing reference select or divider clears lock until relocked.
`timescale 1ns/1ps
`include "clock_gen_defines.vh"
module clock_generator_control_regs #(
    parameter LOCK_WAIT = `LOCK_WAIT_CYCLES
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // AXI4-Lite write address
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Clock enables from the sources
    input wire loop_clk_en,
    input wire int_ref_en,
    input wire ext_ref_en,
    // Power state
    input wire stop_mode,
    input wire loop_locked_raw,
    // Generated enables
    output reg system_clk_en,
    output reg bus_clk_en,
    output reg loop_ref_en,
    output reg internal_ref_clock_out,
    output reg external_ref_clock_out,
    // Oscillator and loop controls
    output reg osc_high_range,
    output reg osc_high_gain,
    output reg external_source_choose,
    output reg loop_enable,
    output reg int_ref_running,
    output reg ext_ref_running,
    // Status
    output reg [1:0] system_source_status,
    output reg lock_status
);
    localparam ST_IDLE = 2'b01;
    localparam ST_RESP = 2'b10;
    // Offsets kept 12 bits wide so the word index is a plain part-select
    localparam [11:0] OFF_ONE = `CTRL_ONE_OFFSET;
    localparam [11:0] OFF_TWO = `CTRL_TWO_OFFSET;
    localparam [11:0] OFF_STATUS = `STATUS_OFFSET;
    localparam [31:0] LOCK_WAIT_32 = LOCK_WAIT;

    reg [7:0] ctrl_one_q;
    reg [7:0] ctrl_two_q;
    reg [1:0] wstate_q;
    reg aw_held_q;
    reg w_held_q;
    reg [11:0] awaddr_q;
    reg [31:0] wdata_q;
    reg wstrb0_q;
    reg stop_q;
    reg stop_int_keep_q;
    reg stop_ext_keep_q;
    reg lock_q;
    reg [6:0] lock_cnt_q;

    wire [1:0] src_sel = ctrl_one_q[`SRC_SEL_HI:`SRC_SEL_LO];
    wire [2:0] ref_div = ctrl_one_q[`REF_DIV_HI:`REF_DIV_LO];
    wire int_choose = ctrl_one_q[`INT_REF_CHOOSE_BIT];
    wire [1:0] bus_div = ctrl_two_q[`BUS_DIV_HI:`BUS_DIV_LO];
    wire low_power = ctrl_two_q[`LOW_POWER_BIT];
    wire [1:0] src_eff = (src_sel == `SRC_RESERVED) ? `SRC_LOOP : src_sel;
    wire [1:0] src_synced;

    // Write channel: address and data taken in either order
    wire aw_fire = s_axi_awvalid && s_axi_awready;
    wire w_fire = s_axi_wvalid && s_axi_wready;
    assign s_axi_awready = (wstate_q == ST_IDLE) && !aw_held_q;
    assign s_axi_wready = (wstate_q == ST_IDLE) && !w_held_q;
    wire have_aw = aw_held_q || aw_fire;
    wire have_w = w_held_q || w_fire;
    wire [11:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held_q ? wdata_q : s_axi_wdata;
    wire wr_lane0 = w_held_q ? wstrb0_q : s_axi_wstrb[0];
    wire wr_go = (wstate_q == ST_IDLE) && have_aw && have_w;
    wire wr_one = wr_go && wr_lane0 && (wr_addr[11:2] == OFF_ONE[11:2]);
    wire wr_two = wr_go && wr_lane0 && (wr_addr[11:2] == OFF_TWO[11:2]);
    wire wr_known = (wr_addr[11:2] == OFF_ONE[11:2]) || (wr_addr[11:2] == OFF_TWO[11:2]);

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wstate_q <= ST_IDLE;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h00000000;
            wstrb0_q <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
        end else begin
            case (wstate_q)
                ST_IDLE: begin
                    if (wr_go) begin
                        aw_held_q <= 1'b0;
                        w_held_q <= 1'b0;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp <= wr_known ? 2'h0 : 2'h2;
                        wstate_q <= ST_RESP;
                    end else begin
                        if (aw_fire) begin
                            aw_held_q <= 1'b1;
                            awaddr_q <= s_axi_awaddr;
                        end
                        if (w_fire) begin
                            w_held_q <= 1'b1;
                            wdata_q <= s_axi_wdata;
                            wstrb0_q <= s_axi_wstrb[0];
                        end
                    end
                end
                ST_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wstate_q <= ST_IDLE;
                    end
                end
                default: begin
                    wstate_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Control registers; only byte lane 0 carries the 8-bit fields
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_one_q <= `CTRL_ONE_RESET;
            ctrl_two_q <= `CTRL_TWO_RESET;
        end else begin
            if (wr_one) begin
                ctrl_one_q <= wr_data[7:0];
            end
            if (wr_two) begin
                ctrl_two_q <= wr_data[7:0];
            end
        end
    end

    // Read channel: one cycle to answer, held until rready
    assign s_axi_arready = !s_axi_rvalid;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'h0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= 2'h0;
            case (s_axi_araddr[11:2])
                OFF_ONE[11:2]: s_axi_rdata <= {24'h000000, ctrl_one_q};
                OFF_TWO[11:2]: s_axi_rdata <= {24'h000000, ctrl_two_q};
                OFF_STATUS[11:2]: s_axi_rdata <= {29'h00000000, lock_q, system_source_status};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= 2'h2;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Loop reference selection and division
    wire ref_chosen_en = int_choose ? int_ref_en : ext_ref_en;
    wire ref_div_en;
    pow2_divider #(.SEL_W(3), .CNT_W(7)) u_ref_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .en_in(ref_chosen_en),
        .power_sel(ref_div),
        .en_out(ref_div_en)
    );

    // Source mux; the settled code drives routing so the switch is glitch-free
    reg sys_pick;
    always @* begin
        case (src_synced)
            `SRC_INTERNAL: sys_pick = int_ref_en;
            `SRC_EXTERNAL: sys_pick = ext_ref_en;
            default: sys_pick = loop_clk_en;
        endcase
    end

    wire bus_en;
    pow2_divider #(.SEL_W(2), .CNT_W(3)) u_bus_div (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .en_in(sys_pick),
        .power_sel(bus_div),
        .en_out(bus_en)
    );

    // Mode status lags the written field by the crossing
    level_sync #(.W(2)) u_mode_sync (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .d_in(src_eff),
        .q_out(src_synced)
    );

    // Stop entry decides which references keep running
    wire stop_rise = stop_mode && !stop_q;
    wire in_int_mode = int_choose || (src_synced == `SRC_INTERNAL);
    wire in_ext_mode = !int_choose || (src_synced == `SRC_EXTERNAL);
    wire bypassed = (src_synced != `SRC_LOOP);
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stop_q <= 1'b0;
            stop_int_keep_q <= 1'b0;
            stop_ext_keep_q <= 1'b0;
        end else begin
            stop_q <= stop_mode;
            if (stop_rise) begin
                stop_int_keep_q <= ctrl_one_q[`INT_REF_STOP_BIT] &&
                    (ctrl_one_q[`INT_REF_OE_BIT] || in_int_mode);
                stop_ext_keep_q <= ctrl_two_q[`EXT_REF_STOP_BIT] &&
                    (ctrl_two_q[`EXT_REF_OE_BIT] || in_ext_mode);
            end
        end
    end

    // Lock tracking: any reference change drops lock until a fresh wait
    wire ref_change = (wr_one && ((wr_data[`REF_DIV_HI:`REF_DIV_LO] != ref_div) ||
        (wr_data[`INT_REF_CHOOSE_BIT] != int_choose)));
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lock_q <= 1'b0;
            lock_cnt_q <= 7'h00;
        end else if (ref_change || stop_mode || !loop_enable || !loop_locked_raw) begin
            lock_q <= 1'b0;
            lock_cnt_q <= 7'h00;
        end else if (lock_cnt_q < LOCK_WAIT_32[6:0]) begin
            lock_cnt_q <= lock_cnt_q + 7'h01;
        end else begin
            lock_q <= 1'b1;
        end
    end

    // Registered outputs
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            system_clk_en <= 1'b0;
            bus_clk_en <= 1'b0;
            loop_ref_en <= 1'b0;
            internal_ref_clock_out <= 1'b0;
            external_ref_clock_out <= 1'b0;
            osc_high_range <= 1'b0;
            osc_high_gain <= 1'b0;
            external_source_choose <= 1'b0;
            loop_enable <= 1'b1;
            int_ref_running <= 1'b1;
            ext_ref_running <= 1'b0;
            system_source_status <= `SRC_LOOP;
            lock_status <= 1'b0;
        end else begin
            system_clk_en <= sys_pick;
            bus_clk_en <= bus_en;
            loop_ref_en <= ref_div_en;
            int_ref_running <= stop_mode ? stop_int_keep_q : 1'b1;
            ext_ref_running <= stop_mode ? stop_ext_keep_q :
                (ctrl_two_q[`EXT_REF_OE_BIT] || in_ext_mode);
            internal_ref_clock_out <= ctrl_one_q[`INT_REF_OE_BIT] && int_ref_en &&
                (!stop_mode || stop_int_keep_q);
            external_ref_clock_out <= ctrl_two_q[`EXT_REF_OE_BIT] && ext_ref_en &&
                (!stop_mode || stop_ext_keep_q);
            osc_high_range <= ctrl_two_q[`RANGE_BIT];
            osc_high_gain <= ctrl_two_q[`HIGH_GAIN_BIT];
            external_source_choose <= ctrl_two_q[`EXT_SRC_BIT];
            loop_enable <= !stop_mode && !(bypassed && low_power);
            system_source_status <= src_synced;
            lock_status <= lock_q;
        end
    end
endmodule // clock_generator_control_regs

// ==== verif/clock_gen_ctrl_assertions.sv ====
// Port-level checks for the clock generator control block.
// Assumes one clock domain and the bind below for every instance.
`timescale 1ns/1ps
module clock_gen_ctrl_assertions #(
    parameter LOCK_WAIT = 64
) (
    // Clock and reset
    input wire clk_sys,
    input wire rst_n,
    // Bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // Source enables and power
    input wire loop_clk_en,
    input wire int_ref_en,
    input wire ext_ref_en,
    input wire stop_mode,
    input wire loop_locked_raw,
    // Generated outputs
    input wire system_clk_en,
    input wire internal_ref_clock_out,
    input wire external_ref_clock_out,
    input wire loop_enable,
    input wire [1:0] system_source_status,
    input wire lock_status
);
    // Saturating run length of raw lock
    reg [7:0] raw_cnt_q;
    wire [7:0] raw_cnt_d = loop_locked_raw ? (raw_cnt_q == 8'hFF ? raw_cnt_q : raw_cnt_q + 8'h01) : 8'h00;
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) raw_cnt_q <= 8'h00;
        else raw_cnt_q <= raw_cnt_d;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    sequence s_stop_entry;
        !stop_mode ##1 stop_mode;
    endsequence
    sequence s_aw_or_w;
        (s_axi_awvalid && s_axi_awready) || (s_axi_wvalid && s_axi_wready);
    endsequence
    property p_route;
        $past(rst_n) && !stop_mode && !$past(stop_mode) |-> system_clk_en == (system_source_status == 2'h1 ?
            $past(int_ref_en) : (system_source_status == 2'h2 ? $past(ext_ref_en) : $past(loop_clk_en)));
    endproperty
    a_route: assert property (p_route) else $error("system enable not from settled source");
    property p_int_gate;
        $past(rst_n) && internal_ref_clock_out |-> $past(int_ref_en);
    endproperty
    a_int_gate: assert property (p_int_gate) else $error("internal output without source pulse");
    property p_ext_gate;
        $past(rst_n) && external_ref_clock_out |-> $past(ext_ref_en);
    endproperty
    a_ext_gate: assert property (p_ext_gate) else $error("external output without source pulse");
    property p_lock_rise;
        $rose(lock_status) |-> raw_cnt_q >= LOCK_WAIT;
    endproperty
    a_lock_rise: assert property (p_lock_rise) else $error("lock set before raw lock held");
    property p_lock_stop;
        s_stop_entry |-> ##[1:3] !lock_status;
    endproperty
    a_lock_stop: assert property (p_lock_stop) else $error("lock kept over stop entry");
    property p_loop_stop;
        stop_mode [*2] |-> !loop_enable;
    endproperty
    a_loop_stop: assert property (p_loop_stop) else $error("loop enabled in stop");
    property p_wr_resp;
        $rose(s_axi_bvalid) |-> $past(s_axi_awvalid && s_axi_awready || s_axi_wvalid && s_axi_wready);
    endproperty
    a_wr_resp: assert property (p_wr_resp) else $error("write response without handshake");
    property p_b_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped early");
    property p_rd_lat;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read data late");
    property p_r_hold;
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped early");
    c_aw_or_w: cover property (s_aw_or_w);
endmodule // clock_gen_ctrl_assertions
bind clock_generator_control_regs clock_gen_ctrl_assertions #(.LOCK_WAIT(LOCK_WAIT)) chk_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .loop_clk_en(loop_clk_en), .int_ref_en(int_ref_en), .ext_ref_en(ext_ref_en),
    .stop_mode(stop_mode), .loop_locked_raw(loop_locked_raw), .system_clk_en(system_clk_en),
    .internal_ref_clock_out(internal_ref_clock_out), .external_ref_clock_out(external_ref_clock_out),
    .loop_enable(loop_enable), .system_source_status(system_source_status), .lock_status(lock_status));

// ==== verif/clock_generator_control_regs_tb.sv ====
// Self-checking bench: register access, dividers, routing, lock and stop keep.
// Assumes the defines header is on the include path.
`timescale 1ns/1ps
`include "clock_gen_defines.vh"
`define CHK(a, e) begin num_checks = num_checks + 1; if ((a) !== (e)) begin n_errors = n_errors + 1; \
    $display("mismatch t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module clock_generator_control_regs_tb;
    localparam LW = 4;
    reg clk_sys = 1'b0;
    reg rst_n = 1'b0;
    reg [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    reg [31:0] s_axi_wdata = 32'h0;
    reg [3:0] s_axi_wstrb = 4'hF;
    reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    reg loop_clk_en = 0, int_ref_en = 1, ext_ref_en = 0, stop_mode = 0, loop_locked_raw = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [1:0] s_axi_bresp, s_axi_rresp, system_source_status;
    wire [31:0] s_axi_rdata;
    wire system_clk_en, bus_clk_en, loop_ref_en, internal_ref_clock_out, external_ref_clock_out;
    wire osc_high_range, osc_high_gain, external_source_choose, loop_enable;
    wire int_ref_running, ext_ref_running, lock_status;
    integer n_errors = 0, num_checks = 0, c_sys, c_bus, c_ref, c_io, c_eo, k;
    reg [31:0] d;
    reg [1:0] r;
    clock_generator_control_regs #(.LOCK_WAIT(LW)) clock_generator_control_regs_i (
        .clk_sys(clk_sys), .rst_n(rst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .loop_clk_en(loop_clk_en), .int_ref_en(int_ref_en), .ext_ref_en(ext_ref_en), .stop_mode(stop_mode),
        .loop_locked_raw(loop_locked_raw), .system_clk_en(system_clk_en), .bus_clk_en(bus_clk_en),
        .loop_ref_en(loop_ref_en), .internal_ref_clock_out(internal_ref_clock_out),
        .external_ref_clock_out(external_ref_clock_out), .osc_high_range(osc_high_range),
        .osc_high_gain(osc_high_gain), .external_source_choose(external_source_choose),
        .loop_enable(loop_enable), .int_ref_running(int_ref_running), .ext_ref_running(ext_ref_running),
        .system_source_status(system_source_status), .lock_status(lock_status));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    // Loop source toggles so routing of code 00 is visible
    always @(posedge clk_sys) loop_clk_en <= ~loop_clk_en;
    task final_report;
        begin
            $display("checks=%0d errors=%0d", num_checks, n_errors);
            if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task wr(input [11:0] a, input [31:0] v);
        integer n;
        reg done;
        begin
            @(posedge clk_sys);
            s_axi_awaddr <= a; s_axi_awvalid <= 1; s_axi_wdata <= v; s_axi_wvalid <= 1; s_axi_bready <= 1;
            done = 0;
            for (n = 0; n < 50 && !done; n = n + 1) begin
                @(posedge clk_sys);
                if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
                if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
                if (s_axi_bvalid === 1'b1) begin done = 1; r = s_axi_bresp; s_axi_bready <= 0; end
            end
            if (!done) begin n_errors = n_errors + 1; final_report; end
        end
    endtask
    task rd(input [11:0] a);
        integer n;
        reg done;
        begin
            @(posedge clk_sys);
            s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
            done = 0;
            for (n = 0; n < 50 && !done; n = n + 1) begin
                @(posedge clk_sys);
                if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
                if (s_axi_rvalid === 1'b1) begin done = 1; d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 0; end
            end
            if (!done) begin n_errors = n_errors + 1; final_report; end
        end
    endtask
    task count(input integer n);
        integer i;
        begin
            c_sys = 0; c_bus = 0; c_ref = 0; c_io = 0; c_eo = 0;
            for (i = 0; i < n; i = i + 1) begin
                @(posedge clk_sys);
                c_sys = c_sys + system_clk_en; c_bus = c_bus + bus_clk_en; c_ref = c_ref + loop_ref_en;
                c_io = c_io + internal_ref_clock_out; c_eo = c_eo + external_ref_clock_out;
            end
        end
    endtask
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd(`CTRL_ONE_OFFSET); `CHK(d, 32'h00000004)
        rd(`CTRL_TWO_OFFSET); `CHK(d, 32'h00000040)
        wr(`CTRL_ONE_OFFSET, 32'h000000A9); rd(`CTRL_ONE_OFFSET); `CHK(d, 32'h000000A9)
        wr(`CTRL_TWO_OFFSET, 32'h0000003D); rd(`CTRL_TWO_OFFSET); `CHK(d, 32'h0000003D)
        `CHK({osc_high_range, osc_high_gain, external_source_choose, loop_enable}, 4'hE)
        wr(12'h010, 32'h000000FF); `CHK(r, 2'h2)
        rd(12'h010); `CHK({r, d}, {2'h2, 32'h0})
        repeat (8) @(posedge clk_sys);
        count(32); `CHK({c_sys, c_ref}, 64'h0)
        // Internal source held high makes divider ratios exact
        for (k = 0; k < 8; k = k + 1) begin
            wr(`CTRL_ONE_OFFSET, {24'h0, 2'h1, k[2:0], 3'h4});
            wr(`CTRL_TWO_OFFSET, {24'h0, k[1:0], 6'h00});
            repeat (8) @(posedge clk_sys);
            count(256);
            `CHK((c_ref >= (256 >> k) - 1) && (c_ref <= (256 >> k) + 1), 1'b1)
            `CHK((c_bus >= (256 >> k[1:0]) - 1) && (c_bus <= (256 >> k[1:0]) + 1), 1'b1)
            `CHK({c_io, osc_high_range, osc_high_gain, external_source_choose}, 35'h0)
        end
        wr(`CTRL_ONE_OFFSET, 32'h000000C4); repeat (8) @(posedge clk_sys);
        rd(`STATUS_OFFSET); `CHK(d, 32'h00000000)
        wr(`CTRL_ONE_OFFSET, 32'h00000044); `CHK(system_source_status, 2'h0)
        repeat (8) @(posedge clk_sys);
        rd(`STATUS_OFFSET); `CHK(d, 32'h00000001)
        loop_locked_raw <= 1'b1;
        repeat (LW + 10) @(posedge clk_sys);
        rd(`STATUS_OFFSET); `CHK(d, 32'h00000005)
        wr(`CTRL_ONE_OFFSET, 32'h0000004C); repeat (2) @(posedge clk_sys);
        `CHK(lock_status, 1'b0)
        ext_ref_en <= 1'b1;
        // Phases: both kept, internal kept by mode only, none kept
        for (k = 0; k < 3; k = k + 1) begin
            wr(`CTRL_ONE_OFFSET, (32'h00070504 >> (8 * (2 - k))) & 32'hFF);
            wr(`CTRL_TWO_OFFSET, (32'h00434140 >> (8 * (2 - k))) & 32'hFF);
            repeat (8) @(posedge clk_sys);
            count(32); `CHK({c_io != 0, c_eo != 0}, k == 0 ? 2'h3 : 2'h0)
            `CHK(loop_enable, 1'b1)
            stop_mode <= 1'b1; repeat (5) @(posedge clk_sys);
            `CHK({int_ref_running, ext_ref_running}, 6'h38 >> (2 * (2 - k)) & 2'h3)
            `CHK(loop_enable, 1'b0)
            stop_mode <= 1'b0; repeat (5) @(posedge clk_sys);
        end
        final_report;
    end
endmodule // clock_generator_control_regs_tb
